// *** nvc_map.svh ***
/*
  Shared numbers of the nested vector controller: vector counts,
  exception numbering, priority and tick timer widths.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef NVC_MAP_SVH
`define NVC_MAP_SVH

`define NVC_NUM_VEC 32
`define NVC_VEC_W 6
`define NVC_EXC_BASE 6'h10
`define NVC_EXC_TICK 6'h0F
`define NVC_PRIO_W 2
`define NVC_PRIO_NONE 3'h4
`define NVC_PINS_PER_PORT 8
`define NVC_TICK_W 24
`define NVC_TICK_ZERO 24'h00_0000
`define NVC_SAVE_CYC 4
`define NVC_CNT_W 4

`endif

// *** nvc_pkg.sv ***
/*
  Types of the nested vector controller: core end state encoding
  and the tick timer state record.
  Assumes nvc_map.svh is on the include path.
*/
`include "nvc_map.svh"

package nvc_pkg;

  // Gray along idle, save, take, run, restore
  typedef enum logic [2:0] {
    NVC_IDLE = 3'h0,
    NVC_SAVE = 3'h1,
    NVC_TAKE = 3'h3,
    NVC_RUN = 3'h2,
    NVC_RESTORE = 3'h6
  } nvc_core_state_t;

  typedef struct packed {
    logic [`NVC_TICK_W-1:0] cnt;
    logic expire;
  } nvc_tick_st_t;

endpackage

// *** nvc_if.sv ***
/*
  Link between the interrupt controller and the processor core:
  vector request and acknowledge, handler return, pin status.
  Assumes both ends run on the same ref_clk and share ce.
*/
`timescale 1ns/1ps
`include "nvc_map.svh"

interface nvc_if #(
  parameter int PIN_N = 48
) ();
  logic irq_req;
  logic [`NVC_VEC_W-1:0] irq_vector;
  logic irq_ack;
  logic irq_done;
  logic [PIN_N-1:0] pin_status;
  logic [PIN_N-1:0] pin_clr;

  modport ctrl (
    output irq_req,
    output irq_vector,
    output pin_status,
    input irq_ack,
    input irq_done,
    input pin_clr
  );

  modport core (
    input irq_req,
    input irq_vector,
    input pin_status,
    output irq_ack,
    output irq_done,
    output pin_clr
  );
endinterface

// *** nvc_tick.sv ***
/*
  24-bit down-counting tick timer with automatic reload.
  Assumes reload comes from logic on ref_clk; reload of zero stops it.
*/
`timescale 1ns/1ps
`include "nvc_map.svh"

module nvc_tick (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic [`NVC_TICK_W-1:0] reload,
  output logic expire
);
  import nvc_pkg::*;

  nvc_tick_st_t r;
  nvc_tick_st_t next_r;

  always_comb begin
    next_r = r;
    next_r.expire = 1'b0;
    if (!enable || reload == `NVC_TICK_ZERO) begin
      next_r.cnt = reload;
    end else if (r.cnt == `NVC_TICK_ZERO) begin
      next_r.cnt = reload - `NVC_TICK_W'(1);
      next_r.expire = 1'b1;
    end else begin
      next_r.cnt = r.cnt - `NVC_TICK_W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign expire = r.expire;
endmodule

// *** nvc_ctrl_end.sv ***
/*
  Nested vector controller, device end: synchronises peripheral and
  port pin requests, keeps pending and active priority state, and
  offers the best preempting vector to the core.
  Assumes the core end shares ref_clk, rst and ce, and that the
  configuration inputs come from logic on ref_clk.
*/
`timescale 1ns/1ps
`include "nvc_map.svh"

module nvc_ctrl_end #(
  parameter int NUM_PORTS = 6,
  parameter int DED_PORTS = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`NVC_NUM_VEC-1:0] periph_irq,
  input wire logic [NUM_PORTS*`NVC_PINS_PER_PORT-1:0] port_pin_irq,
  input wire logic [`NVC_NUM_VEC-1:0] vec_en,
  input wire logic [`NVC_NUM_VEC*`NVC_PRIO_W-1:0] prio_cfg,
  input wire logic tick_en,
  input wire logic [`NVC_TICK_W-1:0] tick_reload,
  input wire logic [`NVC_PRIO_W-1:0] tick_prio,
  output logic all_ports_combined_irq,
  output logic [`NVC_NUM_VEC-1:0] pending_vec,
  output logic [2:0] run_prio,
  nvc_if.ctrl bus
);
  import nvc_pkg::*;

  localparam int PPP = `NVC_PINS_PER_PORT;
  localparam int PIN_N = NUM_PORTS * PPP;
  localparam int NV = `NVC_NUM_VEC;
  localparam int PW = `NVC_PRIO_W;
  localparam int VW = `NVC_VEC_W;
  localparam int LV = 1 << PW;

  if (DED_PORTS < 0 || DED_PORTS >= NUM_PORTS || DED_PORTS + 1 > NV) begin
    $error("nvc_ctrl_end: DED_PORTS must leave ports for combining");
  end

  // Running level is three bits: four levels and none
  if (PW + 1 != $bits(run_prio) || NV != (1 << (VW - 1))) begin
    $error("nvc_ctrl_end: priority width or vector count unsupported");
  end

  typedef struct packed {
    logic [NV-1:0] per_s1;
    logic [NV-1:0] per_s2;
    logic [PIN_N-1:0] pin_s1;
    logic [PIN_N-1:0] pin_s2;
    logic [PIN_N-1:0] pin_stat;
    logic [NV-1:0] pend;
    logic tick_pend;
    logic [LV-1:0] active;
    logic req;
    logic [VW-1:0] vec;
    logic [PW-1:0] req_prio;
    logic comb_irq;
    logic [2:0] run;
  } nvc_ctrl_st_t;

  nvc_ctrl_st_t r;
  nvc_ctrl_st_t next_r;

  logic [NUM_PORTS-1:0] port_any;
  logic [NV-1:0] src;
  logic combined;
  logic tick_hit;

  nvc_tick u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .enable(tick_en),
    .reload(tick_reload),
    .expire(tick_hit)
  );

  assign combined = |r.pin_s2;

  genvar gp;
  genvar gv;
  for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
    assign port_any[gp] = |r.pin_s2[gp*PPP +: PPP];
  end

  for (gv = 0; gv < NV; gv++) begin : g_vec
    if (gv < DED_PORTS) begin : g_ded
      assign src[gv] = port_any[gv];
    end else if (gv == DED_PORTS) begin : g_comb
      assign src[gv] = combined;
    end else begin : g_per
      assign src[gv] = r.per_s2[gv];
    end
  end

  always_comb begin
    logic [NV-1:0] take;
    logic take_tick;
    logic [VW-1:0] idx;
    logic [2:0] run;
    logic [2:0] bp;
    logic [VW-1:0] bv;
    next_r = r;
    take = '0;
    take_tick = 1'b0;
    idx = r.vec - `NVC_EXC_BASE;
    run = `NVC_PRIO_NONE;
    bp = `NVC_PRIO_NONE;
    bv = '0;

    // Pin levels come from outside; two stages each
    next_r.per_s1 = periph_irq;
    next_r.per_s2 = r.per_s1;
    next_r.pin_s1 = port_pin_irq;
    next_r.pin_s2 = r.pin_s1;

    // Sticky pin status, set beats clear
    next_r.pin_stat = (r.pin_stat & ~bus.pin_clr) | r.pin_s2;
    next_r.comb_irq = combined;

    // Acknowledged vector leaves pending
    if (bus.irq_ack) begin
      if (r.vec == `NVC_EXC_TICK) begin
        take_tick = 1'b1;
      end else begin
        take = NV'(1) << idx[4:0];
      end
    end

    // Set wins so a request at acknowledge is kept
    next_r.pend = (r.pend & ~take) | (src & vec_en);
    next_r.tick_pend = (r.tick_pend & ~take_tick) | tick_hit;

    // Running level is highest active one
    for (int i = LV - 1; i >= 0; i--) begin
      if (r.active[i]) begin
        run = 3'(i);
      end
    end

    // Levels nest strictly upward, so top is last in
    // Return retires the running level
    if (bus.irq_done && run != `NVC_PRIO_NONE) begin
      next_r.active[run[PW-1:0]] = 1'b0;
    end
    if (bus.irq_ack) begin
      next_r.active[r.req_prio] = 1'b1;
    end

    // Lowest vector number wins among equal priorities
    for (int v = NV - 1; v >= 0; v--) begin
      if (r.pend[v] && {1'b0, prio_cfg[v*PW +: PW]} <= bp) begin
        bp = {1'b0, prio_cfg[v*PW +: PW]};
        bv = VW'(v) + `NVC_EXC_BASE;
      end
    end
    if (r.tick_pend && {1'b0, tick_prio} <= bp) begin
      bp = {1'b0, tick_prio};
      bv = `NVC_EXC_TICK;
    end

    // Forced low after ack or done: the active level
    // moves one edge later, and a stale compare would
    // offer the vector just taken a second time
    // Strictly higher priority only
    next_r.req = (bp < run) && !bus.irq_ack && !bus.irq_done;
    next_r.vec = bv;
    next_r.req_prio = bp[PW-1:0];
    next_r.run = run;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign bus.irq_req = r.req;
  assign bus.irq_vector = r.vec;
  assign bus.pin_status = r.pin_stat;
  assign all_ports_combined_irq = r.comb_irq;
  assign pending_vec = r.pend;
  // Lags active by one cycle; reads 0 in reset, then none while idle
  assign run_prio = r.run;
endmodule

// *** nvc_core_end.sv ***
/*
  Processor side of the vector link: stacks context, takes the
  offered vector, runs handlers nested and restores on return.
  Assumes the controller end shares ref_clk, rst and ce.
*/
`timescale 1ns/1ps
`include "nvc_map.svh"

module nvc_core_end #(
  parameter int PIN_N = 48,
  parameter int DEPTH = 4,
  parameter int SAVE_CYC = `NVC_SAVE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic handler_finish,
  input wire logic [PIN_N-1:0] pin_clr_req,
  output logic [`NVC_VEC_W-1:0] handler_vector,
  output logic handler_active,
  output logic ctx_busy,
  output logic [$clog2(DEPTH+1)-1:0] nest_depth,
  output logic [PIN_N-1:0] pin_status,
  nvc_if.core bus
);
  import nvc_pkg::*;

  localparam int VW = `NVC_VEC_W;
  localparam int DW = $clog2(DEPTH + 1);
  localparam int CW = `NVC_CNT_W;

  if (DEPTH < (1 << `NVC_PRIO_W) || SAVE_CYC < 1 || SAVE_CYC > (1 << CW)) begin
    $error("nvc_core_end: DEPTH or SAVE_CYC out of range");
  end

  typedef struct packed {
    nvc_core_state_t state;
    logic [CW-1:0] cnt;
    logic [DW-1:0] depth;
    logic [DEPTH-1:0][VW-1:0] stack;
    logic [VW-1:0] cur_vec;
    logic [PIN_N-1:0] clr;
    logic [PIN_N-1:0] stat;
  } nvc_core_st_t;

  nvc_core_st_t r;
  nvc_core_st_t next_r;
  logic ack;
  logic done;

  assign ack = ce && r.state == NVC_TAKE && bus.irq_req;
  assign done = ce && r.state == NVC_RESTORE && r.cnt == '0;

  always_comb begin
    next_r = r;
    next_r.clr = pin_clr_req;
    next_r.stat = bus.pin_status;
    case (r.state)
      NVC_IDLE: begin
        if (bus.irq_req) begin
          next_r.state = NVC_SAVE;
          next_r.cnt = CW'(SAVE_CYC - 1);
        end
      end
      NVC_SAVE: begin
        if (r.cnt == '0) begin
          next_r.state = NVC_TAKE;
        end else begin
          next_r.cnt = r.cnt - CW'(1);
        end
      end
      NVC_TAKE: begin
        if (bus.irq_req) begin
          next_r.stack[r.depth] = bus.irq_vector;
          next_r.cur_vec = bus.irq_vector;
          next_r.depth = r.depth + DW'(1);
          next_r.state = NVC_RUN;
        end else if (r.depth != '0) begin
          next_r.state = NVC_RUN;
        end else begin
          next_r.state = NVC_IDLE;
        end
      end
      NVC_RUN: begin
        if (handler_finish) begin
          next_r.state = NVC_RESTORE;
          next_r.cnt = CW'(SAVE_CYC - 1);
        end else if (bus.irq_req && r.depth < DW'(DEPTH)) begin
          next_r.state = NVC_SAVE;
          next_r.cnt = CW'(SAVE_CYC - 1);
        end
      end
      NVC_RESTORE: begin
        if (r.cnt == '0) begin
          next_r.depth = r.depth - DW'(1);
          if (r.depth > DW'(1)) begin
            next_r.cur_vec = r.stack[r.depth - DW'(2)];
            next_r.state = NVC_RUN;
          end else begin
            next_r.cur_vec = '0;
            next_r.state = NVC_IDLE;
          end
        end else begin
          next_r.cnt = r.cnt - CW'(1);
        end
      end
      default: begin
        next_r.state = NVC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign bus.irq_ack = ack;
  assign bus.irq_done = done;
  assign bus.pin_clr = r.clr;
  assign handler_vector = r.cur_vec;
  assign handler_active = r.state == NVC_RUN;
  assign ctx_busy = r.state == NVC_SAVE || r.state == NVC_RESTORE;
  assign nest_depth = r.depth;
  assign pin_status = r.stat;
endmodule

// *** nvc_props.sv ***
/*
  Link assertions for the vector controller pair.
  Assumes the nvc_if signals, one clock, ce held high.
*/
`timescale 1ns/1ps
`include "nvc_map.svh"

module nvc_props #(
  parameter int PIN_N = 48
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic [`NVC_VEC_W-1:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_done,
  input wire logic [PIN_N-1:0] pin_status,
  input wire logic [PIN_N-1:0] pin_clr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Handlers taken but not yet returned
  logic [2:0] open_cnt;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      open_cnt <= 3'h0;
    end else begin
      open_cnt <= open_cnt + 3'(irq_ack) - 3'(irq_done);
    end
  end

  a_ack_has_req: assert property (irq_ack |-> irq_req)
    else $error("ack without request");
  a_ack_drops_req: assert property (irq_ack |=> !irq_req)
    else $error("request held after ack");
  a_done_drops_req: assert property (irq_done |=> !irq_req)
    else $error("request held after return");
  a_save_then_ack: assert property (irq_ack |-> $past(irq_req, 4))
    else $error("ack before context save");
  a_ack_one_cycle: assert property (irq_ack |=> !irq_ack)
    else $error("ack longer than one cycle");
  a_done_has_open: assert property (irq_done |-> open_cnt != 3'h0)
    else $error("return without taken handler");
  a_nest_bound: assert property (open_cnt <= 3'h4)
    else $error("nesting beyond four levels");
  a_ack_done_excl: assert property (!(irq_ack && irq_done))
    else $error("ack and return together");
  a_vector_range: assert property (irq_req |->
    irq_vector inside {`NVC_EXC_TICK, [6'h10:6'h2F]})
    else $error("vector out of range");
  a_pin_sticky: assert property (
    (($past(pin_status) & ~$past(pin_clr)) & ~pin_status) == '0)
    else $error("pin status lost without clear");
endmodule

// *** tb_nested_irq_with_port_combiner.sv ***
/*
  Testbench of the vector controller pair: all sources, nesting,
  tick and pin status, driven through the core's handler ports.
  Assumes the design files and nvc_map.svh are compiled first.
*/
`timescale 1ns/1ps
`include "nvc_map.svh"

module tb_nested_irq_with_port_combiner;
  import nvc_pkg::*;
  logic ref_clk, rst, handler_finish, tick_en;
  logic [31:0] periph_irq, vec_en, pending_vec;
  logic [47:0] port_pin_irq, pin_clr_req, pin_status;
  logic [63:0] prio_cfg;
  logic [23:0] tick_reload;
  logic [1:0] tick_prio;
  logic all_ports_combined_irq, handler_active, ctx_busy;
  logic [2:0] run_prio, nest_depth;
  logic [5:0] handler_vector;
  int miscompares, comparisons;
  // Core clock and wanted tick rate, in Hz
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_HZ = 1_250_000;

  nvc_if #(.PIN_N(48)) link ();
  nvc_ctrl_end nvc_ctrl_end_inst (.ref_clk, .rst, .ce(1'b1),
    .periph_irq, .port_pin_irq, .vec_en, .prio_cfg, .tick_en,
    .tick_reload, .tick_prio, .all_ports_combined_irq,
    .pending_vec, .run_prio, .bus(link));
  nvc_core_end nvc_core_end_inst (.ref_clk, .rst, .ce(1'b1),
    .handler_finish, .pin_clr_req, .handler_vector, .handler_active,
    .ctx_busy, .nest_depth, .pin_status, .bus(link));
  nvc_props #(.PIN_N(48)) nvc_props_inst (.ref_clk, .rst,
    .irq_req(link.irq_req), .irq_vector(link.irq_vector),
    .irq_ack(link.irq_ack), .irq_done(link.irq_done),
    .pin_status(link.pin_status), .pin_clr(link.pin_clr));

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task automatic test_done();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Bounded wait: 0 request, 1 ack, 2 return
  task automatic await(input int w);
    for (int i = 0; i < 60; i++) begin
      @(negedge ref_clk);
      if ((w == 0 && link.irq_req === 1'b1) ||
          (w == 1 && link.irq_ack === 1'b1) ||
          (w == 2 && link.irq_done === 1'b1)) break;
    end
  endtask

  // Source dropped once offered, so it does not re-pend
  task automatic fire(input int v);
    if (v < 4) port_pin_irq[v*8] = 1'b1;
    else if (v == 4) port_pin_irq[40] = 1'b1;
    else periph_irq[v] = 1'b1;
    await(0);
    chk(all_ports_combined_irq === (v <= 4), "combined");
    if (v == 4) chk(link.pin_status[40] === 1'b1, "pin");
    if (v == 4) chk(pin_status[40] === 1'b1, "core pin");
    port_pin_irq = '0;
    periph_irq = '0;
  endtask

  task automatic take(input logic [5:0] v);
    await(1);
    chk(link.irq_ack === 1'b1 && link.irq_vector === v, "vector");
    @(negedge ref_clk);
    chk(handler_vector === v, "handler");
    chk(handler_active === 1'b1 && ctx_busy === 1'b0, "run");
  endtask

  task automatic fin(input logic [5:0] v);
    handler_finish = 1'b1;
    @(negedge ref_clk);
    handler_finish = 1'b0;
    await(2);
    chk(link.irq_done === 1'b1 && ctx_busy === 1'b1, "return");
    repeat (2) @(negedge ref_clk);
    chk(handler_vector === v, "resume");
    chk(handler_active === (v != 6'h00), "resume state");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Whole run is near 650 cycles
  initial begin
    #400000;
    miscompares++;
    test_done();
  end

  initial begin
    int n;
    rst = 1'b1;
    handler_finish = 1'b0;
    tick_en = 1'b0;
    periph_irq = '0;
    port_pin_irq = '0;
    pin_clr_req = '0;
    vec_en = 32'hFFFF_FFEF;
    tick_reload = 24'(CLK_HZ / TICK_HZ);
    tick_prio = 2'h0;
    prio_cfg = {32{2'h2}};
    prio_cfg[51:50] = 2'h1;
    prio_cfg[53:52] = 2'h3;
    prio_cfg[55:54] = 2'h3;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk(run_prio === 3'h4 && link.irq_req === 1'b0, "idle");
    // Combined vector masked while dedicated ports run
    for (int v = 0; v < 32; v++) begin
      if (v == 4) vec_en = '1;
      fire(v);
      take(6'(16 + v));
      fin(6'h00);
    end
    pin_clr_req = '1;
    @(negedge ref_clk);
    pin_clr_req = '0;
    repeat (4) @(negedge ref_clk);
    chk(link.pin_status === 48'h0000_0000_0000, "clear");
    chk(pin_status === 48'h0000_0000_0000, "core clear");
    fire(26);
    take(6'h2A);
    periph_irq[27] = 1'b1;
    repeat (30) @(negedge ref_clk);
    chk(link.irq_req === 1'b0, "equal");
    chk(pending_vec[27] === 1'b1, "pending");
    periph_irq = '0;
    fire(25);
    take(6'h29);
    chk(nest_depth === 3'h2, "depth");
    fin(6'h2A);
    chk(nest_depth === 3'h1, "unstack");
    chk(run_prio === 3'h3, "resume level");
    fin(6'h00);
    take(6'h2B);
    fin(6'h00);
    chk(run_prio === 3'h4, "all retired");
    tick_en = 1'b1;
    n = 0;
    while (link.irq_req !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n >= 20 && n <= 26, "tick period");
    take(`NVC_EXC_TICK);
    tick_en = 1'b0;
    fin(6'h00);
    test_done();
  end
endmodule
